// >>> verilog/rgbd_pkg.sv
// Shared constants and carrier types for the cascaded RGB LED link receiver.
package rgbd_pkg;

  // ****************************************************************
  // Link timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned BIT_PERIOD_NS = 1200;
  localparam int unsigned THRESH_NS     = 525;
  localparam int unsigned T0_OUT_NS     = 340;
  localparam int unsigned T1_OUT_NS     = 680;
  localparam int unsigned RESET_US      = 140;
  localparam int unsigned PWM_FREQ_HZ   = 7000;
  localparam int unsigned CLK_HZ        = 125_000_000;

  localparam int unsigned BIT_CYC    = BIT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned THRESH_CYC = (THRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T0_CYC     = (T0_OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T1_CYC     = (T1_OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_CYC_DEF =
    (RESET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PWM_PRESC_DEF = CLK_HZ / (PWM_FREQ_HZ * 256);

  // ****************************************************************
  // Word layout
  // ****************************************************************
  localparam int unsigned WORD_W      = 24;
  localparam int unsigned CUR_W       = 5;
  localparam logic [7:0]  CUR_MARK    = 8'hFF;
  localparam int unsigned RED_CUR_LSB = 11;
  localparam int unsigned GRN_CUR_LSB = 6;
  localparam int unsigned BLU_CUR_LSB = 1;
  localparam int unsigned TEST_BIT    = 0;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } rgbd_duty_s;

  typedef struct packed {
    logic [CUR_W-1:0] red;
    logic [CUR_W-1:0] green;
    logic [CUR_W-1:0] blue;
    logic             test;
  } rgbd_cur_s;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_STATUS  = 8'h04;
  localparam logic [7:0]  REG_HELD    = 8'h08;
  localparam logic [7:0]  REG_DUTY    = 8'h0C;
  localparam logic [7:0]  REG_CURRENT = 8'h10;
  localparam int unsigned CTRL_OUT_EN = 0;
  localparam logic        CTRL_RESET  = 1'b1;
  localparam int unsigned ST_HAVE     = 0;
  localparam int unsigned ST_BUSY     = 1;
  localparam int unsigned ST_OVERRUN  = 2;
  localparam int unsigned ST_TEST     = 3;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_LOW  = 3'b010,
    TX_HIGH = 3'b100
  } rgbd_tx_e;

endpackage

// >>> verilog/rgbd_fifo.sv
// Small first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/100ps
module rgbd_fifo #(
  parameter int unsigned W     = 24,
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  wire           wr_en = in_valid_i & in_ready_o;
  wire           rd_en = out_valid_o & out_ready_i;

  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (wr_en) begin
        mem_q[wr_q] <= in_data_i;
        wr_q        <= nxt(wr_q);
      end
      if (rd_en) begin
        rd_q <= nxt(rd_q);
      end
      cnt_q <= cnt_q + (AW+1)'(wr_en) - (AW+1)'(rd_en);
    end
  end

  fifo_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");

endmodule

// >>> verilog/rgbd_pwm.sv
// Three-channel low-active duty generator for the colour outputs.
`timescale 1ns/100ps
module rgbd_pwm
  import rgbd_pkg::*;
#(
  parameter int unsigned PRESC = rgbd_pkg::PWM_PRESC_DEF
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Settings
  input  wire rgbd_pkg::rgbd_duty_s duty_i,
  input  wire logic              test_i,
  input  wire logic              en_i,
  // Colour outputs, low means LED on
  output logic                   red_output_o,
  output logic                   green_output_o,
  output logic                   blue_output_o
);
  logic [15:0] pre_q;
  logic [7:0]  phase_q;
  wire         step = (pre_q == 16'(PRESC - 1));

  // Low while the phase is below the duty: 256 steps, so the mean is duty/256.
  function automatic logic chan(input logic [7:0] duty, input logic [7:0] ph);
    return ~(ph < duty); // [RULE_07] [RULE_08] [RULE_10]
  endfunction

  wire red_d = test_i ? 1'b0 : (!en_i ? 1'b1 : chan(duty_i.red, phase_q)); // [RULE_06]
  wire grn_d = test_i ? 1'b0 : (!en_i ? 1'b1 : chan(duty_i.green, phase_q));
  wire blu_d = test_i ? 1'b0 : (!en_i ? 1'b1 : chan(duty_i.blue, phase_q));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_q          <= '0;
      phase_q        <= '0;
      red_output_o   <= 1'b1;
      green_output_o <= 1'b1;
      blue_output_o  <= 1'b1;
    end else begin
      pre_q          <= step ? '0 : pre_q + 1'b1;
      phase_q        <= step ? phase_q + 1'b1 : phase_q;
      red_output_o   <= red_d;
      green_output_o <= grn_d;
      blue_output_o  <= blu_d;
    end
  end

  duty_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_07]
    (duty_i.red == 8'h00 && !test_i) |=> red_output_o)
    else $error("zero duty did not hold red high");

  duty_full_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_08]
    (duty_i.green == 8'hFF && en_i && !test_i && phase_q != 8'hFF) |=> !green_output_o)
    else $error("full duty did not drive green low");

  test_mode_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_06]
    test_i |=> !blue_output_o) else $error("test mode did not drive blue low");

endmodule

// >>> verilog/rgbd_link.sv
// Single-wire return-to-zero receiver, regenerator and latch for a cascaded RGB driver.
//
// Notes on behaviour
// [RULE_01] First word after reset is kept, not forwarded.
// [RULE_02] Later words are regenerated on the output.
// [RULE_03] Reset level applies held word, rearms reception.
// [RULE_04] Sender bit period is at least 1200 ns.
// [RULE_05] Sender sends red, green, blue, MSB first.
// [RULE_06] Test flag zero gives PWM, one test mode.
// [RULE_07] Duty zero keeps the channel output high.
// [RULE_08] Duty FFH gives the longest low time.
// [RULE_09] Sender never sends duty word with FFH top.
// [RULE_10] Mean current scales with duty over 256.
// [RULE_11] Sender sends current word before duty words.
// [RULE_12] Sender refreshes current word periodically.
// [RULE_13] Top byte all ones marks a current word.
// [RULE_14] Current fields at 15:11, 10:6, 5:1.
// [RULE_15] Bits open low; regenerated lows 340/680 ns.
// [RULE_16] High of 140 us or more is reset.
// [RULE_17] Low time above threshold means a one.
`timescale 1ns/100ps
module rgbd_link
  import rgbd_pkg::*;
#(
  parameter int unsigned RESET_CYC = rgbd_pkg::RESET_CYC_DEF,
  parameter int unsigned PWM_PRESC = rgbd_pkg::PWM_PRESC_DEF
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Serial link
  input  wire logic        din_i,
  output logic             dout_o,
  // Colour outputs and current settings
  output logic             red_output_o,
  output logic             green_output_o,
  output logic             blue_output_o,
  output logic [4:0]       red_current_field_o,
  output logic [4:0]       green_current_field_o,
  output logic [4:0]       blue_current_field_o,
  output logic             test_mode_o,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);
  import rgbd_pkg::*;

  // ****************************************************************
  // Input synchroniser and pulse timing
  // ****************************************************************
  logic        din_s1_q;
  logic        din_s2_q;
  logic        din_prev_q;
  logic [7:0]  low_cnt_q;
  logic [17:0] hi_cnt_q;

  wire rise     = din_s2_q & ~din_prev_q;
  wire fall     = ~din_s2_q & din_prev_q;
  wire rx_bit   = (low_cnt_q >= 8'(THRESH_CYC)); // [RULE_17] [RULE_15]
  wire rst_code = din_s2_q & (hi_cnt_q == 18'(RESET_CYC - 1)); // [RULE_16]

  function automatic logic [17:0] sat_inc(input logic [17:0] v, input logic [17:0] lim);
    return (v >= lim) ? lim : v + 1'b1;
  endfunction

  wire [17:0] low_inc = sat_inc({10'h000, low_cnt_q}, 18'h0_00FF);
  wire [17:0] hi_inc  = sat_inc(hi_cnt_q, 18'(RESET_CYC));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      din_s1_q   <= 1'b1;
      din_s2_q   <= 1'b1;
      din_prev_q <= 1'b1;
      low_cnt_q  <= '0;
      hi_cnt_q   <= '0;
    end else begin
      din_s1_q   <= din_i;
      din_s2_q   <= din_s1_q;
      din_prev_q <= din_s2_q;
      low_cnt_q  <= fall ? 8'h01 : (!din_s2_q ? low_inc[7:0] : low_cnt_q);
      hi_cnt_q   <= din_s2_q ? hi_inc : '0;
    end
  end

  // ****************************************************************
  // Word assembly, hold and latch
  // ****************************************************************
  logic [WORD_W-1:0] shift_q;
  logic [4:0]        nbit_q;
  logic              have_q;
  logic [WORD_W-1:0] held_q;
  rgbd_duty_s        duty_q;
  rgbd_cur_s         cur_q;
  logic              ctrl_en_q;
  logic              overrun_q;
  logic              fifo_ready;

  wire [WORD_W-1:0] new_word  = {shift_q[WORD_W-2:0], rx_bit};
  wire              word_done = rise & (nbit_q == 5'(WORD_W - 1));
  wire              push      = word_done & have_q; // [RULE_02]
  wire              apply     = rst_code & have_q;
  wire              is_cur    = (held_q[23:16] == CUR_MARK); // [RULE_13]
  wire rgbd_cur_s   cur_new   = '{red:   held_q[RED_CUR_LSB +: CUR_W], // [RULE_14]
                                  green: held_q[GRN_CUR_LSB +: CUR_W],
                                  blue:  held_q[BLU_CUR_LSB +: CUR_W],
                                  test:  held_q[TEST_BIT]};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_q <= '0;
      nbit_q  <= '0;
      have_q  <= 1'b0;
      held_q  <= '0;
      duty_q  <= '0;
      cur_q   <= '0;
    end else begin
      if (rst_code) begin
        nbit_q <= '0; // [RULE_03]
      end else if (rise) begin
        shift_q <= new_word;
        nbit_q  <= word_done ? '0 : nbit_q + 1'b1;
      end
      if (word_done && !have_q) begin
        held_q <= new_word; // [RULE_01]
        have_q <= 1'b1;
      end else if (rst_code) begin
        have_q <= 1'b0; // [RULE_03]
      end
      if (apply && is_cur) begin
        cur_q <= cur_new; // [RULE_14]
      end else if (apply) begin
        duty_q <= held_q; // [RULE_03]
      end
    end
  end

  // ****************************************************************
  // Regeneration buffer and transmitter
  // ****************************************************************
  logic              fifo_valid;
  logic [WORD_W-1:0] fifo_data;
  rgbd_tx_e          tx_q;
  logic [WORD_W-1:0] tx_word_q;
  logic [4:0]        tx_bit_q;
  logic [7:0]        tx_cnt_q;

  // The link cannot be stalled, so a word arriving into a full buffer is dropped and flagged.
  rgbd_fifo #(.W(WORD_W), .DEPTH(2)) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (new_word),
    .out_valid_o (fifo_valid),
    .out_ready_i (tx_q == TX_IDLE),
    .out_data_o  (fifo_data)
  );

  wire [7:0] low_len  = tx_word_q[WORD_W-1] ? 8'(T1_CYC) : 8'(T0_CYC); // [RULE_15]
  wire       low_end  = (tx_cnt_q == low_len - 8'h01);
  wire       bit_end  = (tx_cnt_q == 8'(BIT_CYC - 1));
  wire       last_bit = (tx_bit_q == 5'(WORD_W - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_q      <= TX_IDLE;
      tx_word_q <= '0;
      tx_bit_q  <= '0;
      tx_cnt_q  <= '0;
      dout_o    <= 1'b1;
    end else begin
      unique case (tx_q)
        TX_IDLE: begin
          if (fifo_valid) begin
            tx_q      <= TX_LOW;
            tx_word_q <= fifo_data;
            tx_bit_q  <= '0;
            tx_cnt_q  <= '0;
            dout_o    <= 1'b0;
          end
        end
        TX_LOW: begin
          tx_cnt_q <= tx_cnt_q + 1'b1;
          if (low_end) begin
            tx_q   <= TX_HIGH;
            dout_o <= 1'b1;
          end
        end
        TX_HIGH: begin
          tx_cnt_q <= tx_cnt_q + 1'b1;
          if (bit_end && last_bit) begin
            tx_q <= TX_IDLE;
          end else if (bit_end) begin
            tx_q      <= TX_LOW;
            tx_word_q <= {tx_word_q[WORD_W-2:0], 1'b0};
            tx_bit_q  <= tx_bit_q + 1'b1;
            tx_cnt_q  <= '0;
            dout_o    <= 1'b0;
          end
        end
        default: tx_q <= TX_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Colour outputs
  // ****************************************************************
  rgbd_pwm #(.PRESC(PWM_PRESC)) u_pwm (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .duty_i         (duty_q),
    .test_i         (cur_q.test),
    .en_i           (ctrl_en_q),
    .red_output_o   (red_output_o),
    .green_output_o (green_output_o),
    .blue_output_o  (blue_output_o)
  );

  assign red_current_field_o   = cur_q.red;
  assign green_current_field_o = cur_q.green;
  assign blue_current_field_o  = cur_q.blue;
  assign test_mode_o           = cur_q.test;

  // ****************************************************************
  // Wishbone registers
  // ****************************************************************
  wire        req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // A write lands at the edge where the master sees ack, never at the edge it is taken.
  wire        wr      = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire        ovr_clr = wr & (wb_adr_i == REG_STATUS) & wb_dat_i[ST_OVERRUN];
  wire        ovr_set = push & ~fifo_ready;
  wire [31:0] status  = {28'h000_0000, cur_q.test, overrun_q, (tx_q != TX_IDLE), have_q};
  wire [31:0] rd_mux  =
    (wb_adr_i == REG_CTRL)    ? {31'h0000_0000, ctrl_en_q} :
    (wb_adr_i == REG_STATUS)  ? status :
    (wb_adr_i == REG_HELD)    ? {8'h00, held_q} :
    (wb_adr_i == REG_DUTY)    ? {8'h00, duty_q} :
    (wb_adr_i == REG_CURRENT) ? {16'h0000, cur_q} : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= '0;
      ctrl_en_q <= CTRL_RESET;
      overrun_q <= 1'b0;
    end else begin
      wb_ack_o  <= req;
      wb_dat_o  <= req ? rd_mux : wb_dat_o;
      if (wr && wb_adr_i == REG_CTRL) begin
        ctrl_en_q <= wb_dat_i[CTRL_OUT_EN];
      end
      // A new overrun in the clearing cycle wins over the clear.
      overrun_q <= ovr_set | (overrun_q & ~ovr_clr);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  first_word_kept_a: assert property ((word_done && !have_q) |-> // [RULE_01]
    !push ##1 (have_q && held_q == $past(new_word)))
    else $error("first word not kept or was forwarded");

  later_word_fwd_a: assert property ((word_done && have_q && fifo_ready) |=> // [RULE_02]
    ##[0:3] fifo_valid) else $error("later word not queued for regeneration");

  latch_apply_a: assert property ((apply && !is_cur) |=> // [RULE_03]
    (duty_q == $past(held_q)) && !have_q) else $error("held word not applied");

  cur_decode_a: assert property ((apply && is_cur) |=> // [RULE_13]
    (cur_q.red == $past(held_q[15:11]) && duty_q == $past(duty_q)))
    else $error("current word decoded wrongly");

  cur_fields_a: assert property ((apply && is_cur) |=> // [RULE_14]
    (cur_q.green == $past(held_q[10:6]) && cur_q.blue == $past(held_q[5:1])))
    else $error("current fields misplaced");

  bit_class_a: assert property (rise |=> // [RULE_17]
    shift_q[0] == (($past(low_cnt_q) >= 8'(THRESH_CYC)) | $past(rst_code)))
    else $error("bit classified against wrong threshold");

  reset_len_a: assert property ($rose(hi_cnt_q == 18'(RESET_CYC)) |-> // [RULE_16]
    $past(rst_code)) else $error("reset code not flagged at its length");

  regen_low_a: assert property ((tx_q == TX_LOW && tx_cnt_q == 8'h00 && // [RULE_15]
    !tx_word_q[WORD_W-1]) |-> ##43 $rose(dout_o))
    else $error("regenerated zero low time wrong");

  regen_high_a: assert property ((tx_q == TX_LOW && tx_cnt_q == 8'h00 && // [RULE_15]
    tx_word_q[WORD_W-1]) |-> ##85 $rose(dout_o))
    else $error("regenerated one low time wrong");

  bit_period_a: assert property ((tx_q == TX_HIGH && bit_end && !last_bit) |=> // [RULE_15]
    (!dout_o && tx_cnt_q == 8'h00)) else $error("regenerated bit period wrong");

endmodule

// >>> sim/rgbd_src.sv
// Upstream controller model that drives the single-wire link.
`timescale 1ns/100ps
module rgbd_src (
  // Clock
  input  wire logic clk_i,
  // Serial line towards the receiver
  output logic      din_o
);
  initial din_o = 1'b1;

  // ****************************************************************
  // Bit and reset framing
  // ****************************************************************
  // Mode 0 sends typical low times, 1 the shortest and 2 the longest legal ones.
  task automatic send_bits(input logic [23:0] w, input int n, input int mode);
    int lo;
    for (int i = 23; i > 23 - n; i--) begin
      if (w[i]) lo = (mode == 1) ? 75 : (mode == 2) ? 125 : 100;
      else lo = (mode == 1) ? 19 : (mode == 2) ? 56 : 38;
      @(posedge clk_i);
      din_o <= 1'b0;
      repeat (lo) @(posedge clk_i);
      din_o <= 1'b1;
      repeat (149 - lo) @(posedge clk_i);
    end
  endtask

  // The line simply stays at its idle high level for the reset code.
  task automatic send_reset(input int n);
    repeat (n) @(posedge clk_i);
  endtask
endmodule

// >>> sim/rgbd_link_bench.sv
// Self-checking bench for the cascaded RGB link receiver.
`timescale 1ns/100ps
module rgbd_link_bench;
  import rgbd_pkg::*;
  localparam int unsigned RST_CYC = 200;
  logic        clk_i, rst_i, din_i, dout_o, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        red_o, grn_o, blu_o, test_o;
  logic [4:0]  cr_o, cg_o, cb_o;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, t, seed;
  logic [3:0]  wb_sel_i;
  logic [23:0] sh, held, cw;
  logic [23:0] got_q[$], exp_q[$];
  int          bad_count, tests_run, cyc_n, nlow, nbit, mr, mg, mb, mt, dr, dg, db;
  bit          have, en;

  rgbd_link #(.RESET_CYC(RST_CYC), .PWM_PRESC(1)) rgbd_link_inst (
    .clk_i(clk_i), .rst_i(rst_i), .din_i(din_i), .dout_o(dout_o),
    .red_output_o(red_o), .green_output_o(grn_o), .blue_output_o(blu_o),
    .red_current_field_o(cr_o), .green_current_field_o(cg_o),
    .blue_current_field_o(cb_o), .test_mode_o(test_o),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
  );
  rgbd_src rgbd_src_inst (.clk_i(clk_i), .din_o(din_i));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Duty words never carry an all-ones top byte.
  function automatic logic [23:0] rnd_duty();
    logic [31:0] v;
    v = xs();
    if (v[23:16] == 8'hFF) v[23:16] = 8'hFE;
    return v[23:0];
  endfunction

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic send(input logic [23:0] w, input int mode);
    if (have) exp_q.push_back(w);
    else held = w;
    have = 1;
    rgbd_src_inst.send_bits(w, 24, mode);
  endtask

  // Reset code, then the model applies its held word and the results are compared.
  task automatic rcode();
    rgbd_src_inst.send_reset(RST_CYC + 30);
    if (have && held[23:16] == 8'hFF) begin
      mr = held[15:11];
      mg = held[10:6];
      mb = held[5:1];
      mt = held[0];
    end else if (have) begin
      dr = held[23:16];
      dg = held[15:8];
      db = held[7:0];
    end
    have = 0;
    for (int k = 0; k < 4000 && got_q.size() < exp_q.size(); k++) @(posedge clk_i);
    chk("fwd_count", got_q.size(), exp_q.size());
    while (got_q.size() > 0 && exp_q.size() > 0) begin
      chk("fwd_word", got_q.pop_front(), exp_q.pop_front());
    end
    got_q.delete();
    exp_q.delete();
    chk("red_cur", cr_o, mr);
    chk("grn_cur", cg_o, mg);
    chk("blu_cur", cb_o, mb);
    chk("test", test_o, mt);
  endtask

  task automatic pwm_chk();
    int lr = 0, lg = 0, lb = 0;
    repeat (4) @(posedge clk_i);
    repeat (256) begin
      @(posedge clk_i);
      lr += (red_o === 1'b0);
      lg += (grn_o === 1'b0);
      lb += (blu_o === 1'b0);
    end
    chk("red_low", lr, mt ? 256 : en ? dr : 0);
    chk("grn_low", lg, mt ? 256 : en ? dg : 0);
    chk("blu_low", lb, mt ? 256 : en ? db : 0);
  endtask

  // ****************************************************************
  // Regenerated output monitor and watchdog
  // ****************************************************************
  always @(posedge clk_i) begin
    if (rst_i === 1'b0 && dout_o === 1'b0) nlow++;
    else if (nlow > 0) begin
      chk("dout_low", nlow, (nlow > 64) ? 85 : 43);
      sh = {sh[22:0], nlow > 64};
      nlow = 0;
      nbit++;
      if (nbit == 24) begin
        got_q.push_back(sh);
        nbit = 0;
      end
    end
  end

  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 60000) begin
      bad_count++;
      final_report();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    seed = 32'h0001_4451;
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = {1'b1, 47'h0};
    {bad_count, tests_run, cyc_n, nlow, nbit, mr, mg, mb, mt, dr, dg, db} = '0;
    have = 0;
    en = 1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_sel_i <= 4'hF;
    @(posedge clk_i);
    chk("rst_out", {dout_o, red_o, grn_o, blu_o, test_o, cr_o, cg_o, cb_o}, 20'hF_0000);
    wb(0, REG_CTRL, 0);
    chk("ctrl_rst", rd, 1);
    wb(0, REG_STATUS, 0);
    chk("status_rst", rd, 0);
    wb(1, 8'h20, xs());
    wb(0, 8'h20, 0);
    chk("unmapped", rd, 0);
    cw = {8'hFF, 5'd9, 5'd20, 5'd31, 1'b0};
    send(cw, 0);
    wb(0, REG_HELD, 0);
    chk("held", rd, cw);
    wb(0, REG_STATUS, 0);
    chk("have", rd[ST_HAVE], 1);
    send(rnd_duty(), 1);
    wb(0, REG_STATUS, 0);
    chk("busy", rd[3:1], 3'b001);
    send(rnd_duty(), 2);
    rcode();
    wb(0, REG_CURRENT, 0);
    chk("cur_reg", rd, {16'h0, cw[15:0]});
    t = xs();
    send({8'h00, 8'hFF, t[7:0]}, 0);
    rcode();
    pwm_chk();
    wb(0, REG_DUTY, 0);
    chk("duty_reg", rd, {16'h00FF, t[7:0]});
    wb(1, REG_CTRL, xs() & 32'hFFFF_FFFE);
    en = 0;
    pwm_chk();
    wb(1, REG_CTRL, 32'h0000_0001);
    en = 1;
    t = xs();
    rgbd_src_inst.send_bits(t[23:0], 8, 0);
    rcode();
    send(rnd_duty(), 1);
    rcode();
    pwm_chk();
    send({8'hFF, 15'h1234, 1'b1}, 2);
    rcode();
    wb(0, REG_STATUS, 0);
    chk("st_test", rd[ST_TEST], 1);
    pwm_chk();
    send(cw, 1);
    rcode();
    pwm_chk();
    final_report();
  end
endmodule
